// ---- wrxcs_regs.vh ----
/*
 Constants for the wireless receiver charge supervisor: timing figures, packet codes and encodings.
 Assumes the includer works on a 250 MHz system clock; the cycle counts below are sized for that clock.
*/
// Contract
// R1: Start charging only inside T1-T4 window.
// R2: Suspend outside window, resume when back inside.
// R3: Standard variant halves current in outer zones.
// R4: Standard variant: normal voltage T1-T3, reduced T3-T4.
// R5: Modified variant keeps full current in zones.
// R6: Modified variant reduces voltage in T3-T4 zone.
// R7: Surge: control errors every 32 ms, else 250.
// R8: Overvoltage opens pass switch, requests voltage return.
// R9: End packet uses header 0x02 with reason.
// R10: Reason 0x00 adapter/ctrl high; 0x02 internal fault.
// R11: Reason 0x01 on taper termination, then high-Z.
// R12: Reason 0x03 on hot, cold or ctrl low.
// R13: Reason 0x06 on precharge or fast timeout.
// R14: Reason 0x08 when rectifier fails to converge.
// R15: Status pin low exactly while charger enabled.
// R16: Charger stays off until rectifier converged.
// R17: Two load switches encode outgoing packets.
// R18: Fixed current limit while a packet modulates.
// R19: Diode rectification during initial start-up.
// R20: Half sync above lockout; full sync with hysteresis.
// R21: Hot and cold comparators checked on temperature.
// R22: Bias 25ms, deglitch 10ms, release 100ms.
// R23: Ctrl pin high or low shuts receiver down.
// R24: Analog comparator inputs synchronised to system clock.
`ifndef WRXCS_REGS_VH
`define WRXCS_REGS_VH
`define WRX_CLK_KHZ        250000
`define WRX_CE_FAST_MS     32
`define WRX_CE_SLOW_MS     250
`define WRX_TS_BIAS_MS     25
`define WRX_TS_DEGLITCH_MS 10
`define WRX_TS_RELEASE_MS  100
`define WRX_BIT_US         500
`define WRX_CE_FAST_CYC    27'h07A_1200
`define WRX_CE_SLOW_CYC    27'h3B9_ACA0
`define WRX_TS_BIAS_CYC    27'h05F_5E10
`define WRX_TS_DGL_CYC     27'h026_25A0
`define WRX_TS_REL_CYC     27'h17D_7840
`define WRX_BIT_CYC        27'h001_E848
`define WRX_HDR_EPT        8'h02
`define WRX_HDR_CE         8'h03
`define WRX_EPT_UNKNOWN    8'h00
`define WRX_EPT_COMPLETE   8'h01
`define WRX_EPT_INTFAULT   8'h02
`define WRX_EPT_OVERTEMP   8'h03
`define WRX_EPT_BATTFAIL   8'h06
`define WRX_EPT_NORESP     8'h08
`define WRX_ILIM_FULL      2'h0
`define WRX_ILIM_HALF      2'h1
`define WRX_ILIM_COMM      2'h2
`define WRX_RECT_DIODE     2'h0
`define WRX_RECT_HALF      2'h1
`define WRX_RECT_FULL      2'h2
`endif

// ---- wrxcs_sync2.v ----
/*
 Two-flop synchroniser for a vector of independent level signals.
 Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/100ps
module wrxcs_sync2 #(
	parameter W = 1
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire [W-1:0] asyncIn,
	output wire [W-1:0] syncOut
);
	reg [W-1:0] meta_q;
	reg [W-1:0] stable_q;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q   <= {W{1'b0}};
			stable_q <= {W{1'b0}};
		end else begin
			meta_q   <= asyncIn;
			stable_q <= meta_q;
		end
	end

	assign syncOut = stable_q;
endmodule

// ---- wrxcs_modulator.v ----
/*
 Serial load-modulation sender: one header byte then one data byte, MSB first, each bit held BIT_CYC cycles.
 Assumes the caller raises start only while busy is low; a start during busy is ignored.
*/
`timescale 1ns/100ps
`include "wrxcs_regs.vh"
module wrxcs_modulator #(
	parameter [26:0] BIT_CYC = `WRX_BIT_CYC
) (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire       start,
	input  wire [7:0] header,
	input  wire [7:0] payload,
	output wire       busy,
	output wire       switchOn
);
	reg [15:0] shift_q;
	reg [4:0]  bitsLeft_q;
	reg [26:0] bitCnt_q;
	reg        sw_q;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shift_q    <= 16'h0000;
			bitsLeft_q <= 5'h00;
			bitCnt_q   <= 27'h000_0000;
			sw_q       <= 1'b0;
		end else if (bitsLeft_q == 5'h00) begin
			sw_q <= 1'b0;
			if (start) begin
				shift_q    <= {header[6:0], payload, 1'b0};
				sw_q       <= header[7];
				bitsLeft_q <= 5'h10;
				bitCnt_q   <= 27'h000_0000;
			end
		end else if (bitCnt_q == BIT_CYC - 27'h000_0001) begin
			bitCnt_q   <= 27'h000_0000;
			bitsLeft_q <= bitsLeft_q - 5'h01;
			sw_q       <= (bitsLeft_q == 5'h01) ? 1'b0 : shift_q[15];
			shift_q    <= {shift_q[14:0], 1'b0};
		end else begin
			bitCnt_q <= bitCnt_q + 27'h000_0001;
		end
	end

	assign busy     = (bitsLeft_q != 5'h00);
	assign switchOn = sw_q;
endmodule

// ---- wrxcs_top.v ----
/*
 Charge supervisor: temperature gating, profile selection, control-error pacing, end-transfer reasons,
 status pin, load modulation and rectifier mode stepping.
 Assumes every analog comparator input is an asynchronous level; the analog loops act on the select outputs.
*/
`timescale 1ns/100ps
`include "wrxcs_regs.vh"
module wrxcs_top #(
	parameter [26:0] CE_FAST_CYC  = `WRX_CE_FAST_CYC,
	parameter [26:0] CE_SLOW_CYC  = `WRX_CE_SLOW_CYC,
	parameter [26:0] TS_BIAS_CYC  = `WRX_TS_BIAS_CYC,
	parameter [26:0] TS_DGL_CYC   = `WRX_TS_DGL_CYC,
	parameter [26:0] TS_REL_CYC   = `WRX_TS_REL_CYC,
	parameter [26:0] BIT_CYC      = `WRX_BIT_CYC
) (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire       variantModified,
	input  wire       tsAboveT1,
	input  wire       tsAboveT2,
	input  wire       tsAboveT3,
	input  wire       tsAboveT4,
	input  wire       tsHot,
	input  wire       tsCold,
	input  wire       ctrlAboveHigh,
	input  wire       ctrlBelowLow,
	input  wire       adapterPresent,
	input  wire       junctionHot,
	input  wire       ilimShorted,
	input  wire       rectSurge,
	input  wire       rectAcceptable,
	input  wire       rectOverVolt,
	input  wire       rectAboveLockout,
	input  wire       rectConverged,
	input  wire       rectConvergeFail,
	input  wire       loadAboveSyncEntry,
	input  wire       loadBelowSyncExit,
	input  wire       taperPhase,
	input  wire       battBelowTerm,
	input  wire       prechargeTimeout,
	input  wire       fastChargeTimeout,
	input  wire [7:0] controlErrorValue,
	output reg        tsBiasEn,
	output reg        chargeEn,
	output reg        highImpedance,
	output reg        passSwitchOn,
	output reg  [1:0] currentLimitSel,
	output reg        reducedVoltage,
	output reg  [1:0] rectMode,
	output wire       chargeStatusOut,
	output wire       chargeStatusOe,
	output wire       loadModSwitchA,
	output wire       loadModSwitchB,
	output wire       eptSent
);
	localparam NIN = 24;
	localparam [2:0] ST_WAIT   = 3'h0;
	localparam [2:0] ST_CHARGE = 3'h1;
	localparam [2:0] ST_SUSP   = 3'h2;
	localparam [2:0] ST_EPT    = 3'h3;
	localparam [2:0] ST_OFF    = 3'h4;

	wire [NIN-1:0] rawIn;
	wire [NIN-1:0] syncIn;

	assign rawIn = {variantModified, tsAboveT1, tsAboveT2, tsAboveT3, tsAboveT4, tsHot, tsCold,
		ctrlAboveHigh, ctrlBelowLow, adapterPresent, junctionHot, ilimShorted, rectSurge,
		rectAcceptable, rectOverVolt, rectAboveLockout, rectConverged, rectConvergeFail,
		loadAboveSyncEntry, loadBelowSyncExit, taperPhase, battBelowTerm, prechargeTimeout,
		fastChargeTimeout};

	// Every comparator level passes two flops before any logic reads it.
	wrxcs_sync2 #(
		.W       (NIN)
	) wrxcs_sync2_i (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.asyncIn (rawIn),
		.syncOut (syncIn)
	); // R24

	wire       sModified = syncIn[23];
	wire [5:0] tsRaw     = syncIn[22:17];
	wire       sCtrlHi   = syncIn[16];
	wire       sCtrlLo   = syncIn[15];
	wire       sAdapter  = syncIn[14];
	wire       sJunction = syncIn[13];
	wire       sIlimShrt = syncIn[12];
	wire       sSurge    = syncIn[11];
	wire       sAccept   = syncIn[10];
	wire       sOverVolt = syncIn[9];
	wire       sLockout  = syncIn[8];
	wire       sConverge = syncIn[7];
	wire       sConvFail = syncIn[6];
	wire       sLoadHi   = syncIn[5];
	wire       sLoadLo   = syncIn[4];
	wire       sTaper    = syncIn[3];
	wire       sBelowTrm = syncIn[2];
	wire       sPreTmo   = syncIn[1];
	wire       sFastTmo  = syncIn[0];

	// Temperature pin sampling: bias window with deglitched comparators, then released pin watch.
	reg [26:0] tsCnt_q;
	reg [26:0] dglCnt_q;
	reg [5:0]  tsSeen_q;
	reg [5:0]  tsFilt_q;
	reg        tsValid_q;
	reg        ctrlHiSeen_q;
	reg        ctrlLoSeen_q;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tsBiasEn     <= 1'b1;
			tsCnt_q      <= 27'h000_0000;
			dglCnt_q     <= 27'h000_0000;
			tsSeen_q     <= 6'h00;
			tsFilt_q     <= 6'h00;
			tsValid_q    <= 1'b0;
			ctrlHiSeen_q <= 1'b0;
			ctrlLoSeen_q <= 1'b0;
		end else begin
			tsCnt_q <= tsCnt_q + 27'h000_0001;
			if (tsBiasEn && tsCnt_q == TS_BIAS_CYC - 27'h000_0001) begin
				tsBiasEn <= 1'b0;
				tsCnt_q  <= 27'h000_0000;
			end else if (!tsBiasEn && tsCnt_q == TS_REL_CYC - 27'h000_0001) begin
				tsBiasEn <= 1'b1;
				tsCnt_q  <= 27'h000_0000;
			end // R22
			if (tsBiasEn) begin
				tsSeen_q <= tsRaw;
				if (tsRaw != tsSeen_q) begin
					dglCnt_q <= 27'h000_0000;
				end else if (dglCnt_q == TS_DGL_CYC - 27'h000_0001) begin
					tsFilt_q  <= tsSeen_q;
					tsValid_q <= 1'b1;
				end else begin
					dglCnt_q <= dglCnt_q + 27'h000_0001;
				end // R22
				if (sCtrlLo) begin
					ctrlLoSeen_q <= 1'b1;
				end // R23
			end else begin
				dglCnt_q <= 27'h000_0000;
				if (sCtrlHi) begin
					ctrlHiSeen_q <= 1'b1;
				end // R23
			end
		end
	end

	wire fT1   = tsFilt_q[5];
	wire fT2   = tsFilt_q[4];
	wire fT3   = tsFilt_q[3];
	wire fT4   = tsFilt_q[2];
	wire fHot  = tsFilt_q[1];
	wire fCold = tsFilt_q[0];
	wire inWindow = tsValid_q && fT1 && !fT4; // R1
	wire zoneLow  = fT1 && !fT2;
	wire zoneHigh = fT3 && !fT4;
	wire tempFault = tsValid_q && (fHot || fCold); // R21

	// End-transfer reason, highest priority first.
	reg       eptNeed;
	reg [7:0] eptReason;

	always @* begin
		eptNeed   = 1'b1;
		eptReason = `WRX_EPT_UNKNOWN;
		if (sJunction || sIlimShrt) begin
			eptReason = `WRX_EPT_INTFAULT; // R10
		end else if (tempFault || ctrlLoSeen_q) begin
			eptReason = `WRX_EPT_OVERTEMP; // R12
		end else if (sAdapter || ctrlHiSeen_q) begin
			eptReason = `WRX_EPT_UNKNOWN; // R10
		end else if (sPreTmo || sFastTmo) begin
			eptReason = `WRX_EPT_BATTFAIL; // R13
		end else if (sConvFail) begin
			eptReason = `WRX_EPT_NORESP; // R14
		end else if (chargeEn && sTaper && sBelowTrm) begin
			eptReason = `WRX_EPT_COMPLETE; // R11
		end else begin
			eptNeed = 1'b0;
		end
	end

	// Charge sequencing and the packet scheduler share the modulator.
	reg  [2:0]  state_q;
	reg  [7:0]  eptCode_q;
	reg         surge_q;
	reg  [26:0] ceCnt_q;
	reg         modStart;
	reg  [7:0]  modHeader;
	reg  [7:0]  modPayload;
	reg         eptSent_q;
	wire        modBusy;
	wire        modSwitch;
	wire [26:0] ceInterval = surge_q ? CE_FAST_CYC : CE_SLOW_CYC;
	wire        ceDue      = (ceCnt_q >= ceInterval - 27'h000_0001);

	always @* begin
		modStart   = 1'b0;
		modHeader  = `WRX_HDR_CE;
		modPayload = controlErrorValue;
		if (!modBusy) begin
			if (state_q == ST_EPT) begin
				modStart   = 1'b1;
				modHeader  = `WRX_HDR_EPT; // R9
				modPayload = eptCode_q;
			end else if (state_q != ST_OFF && ceDue) begin
				modStart = 1'b1; // R7
			end
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= ST_WAIT;
			eptCode_q <= 8'h00;
			surge_q   <= 1'b0;
			ceCnt_q   <= 27'h000_0000;
			eptSent_q <= 1'b0;
		end else begin
			eptSent_q <= 1'b0;
			// A surge or overvoltage asks for fast pacing until the rectifier settles.
			if (sSurge || sOverVolt) begin
				surge_q <= 1'b1; // R8
			end else if (sAccept) begin
				surge_q <= 1'b0; // R7
			end
			if (modStart && modHeader == `WRX_HDR_CE) begin
				ceCnt_q <= 27'h000_0000;
			end else if (!ceDue) begin
				ceCnt_q <= ceCnt_q + 27'h000_0001;
			end
			case (state_q)
				ST_WAIT, ST_CHARGE, ST_SUSP: begin
					if (eptNeed) begin
						eptCode_q <= eptReason;
						state_q   <= ST_EPT;
					end else if (state_q == ST_CHARGE && !inWindow) begin
						state_q <= ST_SUSP; // R2
					end else if (state_q != ST_CHARGE && inWindow && sConverge) begin
						state_q <= ST_CHARGE; // R1
					end
				end
				ST_EPT: begin
					if (modStart) begin
						eptSent_q <= 1'b1;
						state_q   <= ST_OFF; // R11
					end
				end
				ST_OFF: begin
					state_q <= ST_OFF;
				end
				default: begin
					state_q <= ST_WAIT;
				end
			endcase
		end
	end

	wrxcs_modulator #(
		.BIT_CYC  (BIT_CYC)
	) wrxcs_modulator_i (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.start    (modStart),
		.header   (modHeader),
		.payload  (modPayload),
		.busy     (modBusy),
		.switchOn (modSwitch)
	);

	// Both switches move together so either capacitive or paralleled resistive modulation works.
	assign loadModSwitchA = modSwitch; // R17
	assign loadModSwitchB = modSwitch; // R17

	// Charger outputs and profile selection.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			chargeEn        <= 1'b0;
			highImpedance   <= 1'b0;
			passSwitchOn    <= 1'b0;
			currentLimitSel <= `WRX_ILIM_FULL;
			reducedVoltage  <= 1'b0;
		end else begin
			chargeEn      <= (state_q == ST_CHARGE) && sConverge && !eptNeed; // R16
			highImpedance <= (state_q == ST_OFF); // R11
			passSwitchOn  <= !sOverVolt && (state_q != ST_OFF); // R8
			if (modBusy) begin
				currentLimitSel <= `WRX_ILIM_COMM; // R18
			end else if (!sModified && (zoneLow || zoneHigh)) begin
				currentLimitSel <= `WRX_ILIM_HALF; // R3
			end else begin
				currentLimitSel <= `WRX_ILIM_FULL; // R5
			end
			// Both variants use the reduced target in the warm zone; normal below the third threshold.
			reducedVoltage <= zoneHigh; // R4 R6
		end
	end

	// Open-drain status pin pulls low while the charger output is on.
	assign chargeStatusOut = 1'b0;
	assign chargeStatusOe  = chargeEn; // R15
	assign eptSent         = eptSent_q;

	// Rectifier mode stepping with hysteresis between the two load-current levels.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rectMode <= `WRX_RECT_DIODE; // R19
		end else begin
			case (rectMode)
				`WRX_RECT_DIODE: begin
					if (sLockout) begin
						rectMode <= `WRX_RECT_HALF; // R20
					end
				end
				`WRX_RECT_HALF: begin
					if (!sLockout) begin
						rectMode <= `WRX_RECT_DIODE; // R19
					end else if (sLoadHi) begin
						rectMode <= `WRX_RECT_FULL; // R20
					end
				end
				`WRX_RECT_FULL: begin
					if (!sLockout) begin
						rectMode <= `WRX_RECT_DIODE;
					end else if (sLoadLo) begin
						rectMode <= `WRX_RECT_HALF; // R20
					end
				end
				default: begin
					rectMode <= `WRX_RECT_DIODE;
				end
			endcase
		end
	end
endmodule

// ---- wrxcs_assertions.sv ----
/*
 Port checker for the charge supervisor top.
 Assumes it is bound into wrxcs_top and handed the same bit and bias timing parameters.
*/
`timescale 1ns/100ps
module wrxcs_assertions #(
	parameter int BIT_CYC     = 4,
	parameter int TS_BIAS_CYC = 100
) (
	input wire       clk_sys,
	input wire       rst_n,
	input wire       rectOverVolt,
	input wire       rectAboveLockout,
	input wire       tsBiasEn,
	input wire       chargeEn,
	input wire       highImpedance,
	input wire       passSwitchOn,
	input wire [1:0] currentLimitSel,
	input wire [1:0] rectMode,
	input wire       chargeStatusOut,
	input wire       chargeStatusOe,
	input wire       loadModSwitchA,
	input wire       loadModSwitchB,
	input wire       eptSent
);
	localparam int B6 = 6 * BIT_CYC;
	localparam int B1 = BIT_CYC - 1;
	logic [15:0] hiCnt_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// A counter stands in for a long repetition, which the tools would unroll.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hiCnt_q <= 16'h0000;
		end else begin
			hiCnt_q <= tsBiasEn ? hiCnt_q + 16'h0001 : 16'h0000;
		end
	end
	property p_status;
		chargeStatusOe == chargeEn && !chargeStatusOut;
	endproperty
	a_status: assert property (p_status) else $error("status pin differs from charger enable");
	property p_twin;
		loadModSwitchA == loadModSwitchB;
	endproperty
	a_twin: assert property (p_twin) else $error("load switches differ");
	property p_limit;
		loadModSwitchA && $past(loadModSwitchA) |-> currentLimitSel == 2'h2;
	endproperty
	a_limit: assert property (p_limit) else $error("no fixed limit while modulating");
	property p_ovp;
		rectOverVolt [*6] |-> !passSwitchOn;
	endproperty
	a_ovp: assert property (p_ovp) else $error("pass switch on during overvoltage");
	property p_hiz;
		highImpedance |-> !chargeEn && !passSwitchOn;
	endproperty
	a_hiz: assert property (p_hiz) else $error("output active in high impedance");
	property p_ept;
		$rose(eptSent) |-> !loadModSwitchA ##B6 loadModSwitchA ##B1 loadModSwitchA ##1 !loadModSwitchA;
	endproperty
	a_ept: assert property (p_ept) else $error("end packet header bits wrong");
	property p_full;
		rectMode == 2'h2 |-> $past(rectMode) != 2'h0;
	endproperty
	a_full: assert property (p_full) else $error("diode mode jumped to full sync");
	property p_diode;
		!rectAboveLockout [*5] |-> rectMode == 2'h0;
	endproperty
	a_diode: assert property (p_diode) else $error("sync mode below lockout");
	property p_bias;
		$fell(tsBiasEn) |-> hiCnt_q >= TS_BIAS_CYC - 1 && hiCnt_q <= TS_BIAS_CYC + 2;
	endproperty
	a_bias: assert property (p_bias) else $error("bias window length wrong");
endmodule
bind wrxcs_top wrxcs_assertions #(.BIT_CYC(BIT_CYC), .TS_BIAS_CYC(TS_BIAS_CYC)) wrxcs_assertions_i (
	.clk_sys, .rst_n, .rectOverVolt, .rectAboveLockout, .tsBiasEn, .chargeEn, .highImpedance,
	.passSwitchOn, .currentLimitSel, .rectMode, .chargeStatusOut, .chargeStatusOe,
	.loadModSwitchA, .loadModSwitchB, .eptSent);

// ---- wrxcs_tx_model.sv ----
/*
 Transmitter model: decodes load-modulated packets and lets the rectifier converge after a control error.
 Assumes a frame starts one cycle before the communication current limit appears.
*/
`timescale 1ns/100ps
module wrxcs_tx_model #(
	parameter int BIT_CYC = 4,
	parameter int SETTLE  = 50
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire         sw,
	input  wire         frameOn,
	output logic        converged,
	output logic [15:0] lastPkt,
	output int          pktCount,
	output int          startCyc
);
	int         c = 0;
	int         n = 16;
	int         now = 0;
	int         hold = -1;
	logic       onQ = 1'b0;
	logic [15:0] sh;
	int         pkts = 0;
	// The packet count survives a receiver reset so the bench can tell old packets from new ones.
	assign pktCount = pkts;
	// Sampling mid-bit keeps the decode clear of the bit edges.
	always @(posedge clk_sys) begin
		now <= now + 1;
		onQ <= frameOn;
		if (!rst_n) begin
			converged <= 1'b0;
			hold = -1;
		end else if (hold > 0) begin
			hold = hold - 1;
		end else if (hold == 0) begin
			converged <= 1'b1;
		end
		if (frameOn && !onQ) begin
			c = 1;
			n = 0;
			startCyc <= now - 1;
		end else if (n < 16) begin
			c = c + 1;
			if (c % BIT_CYC == BIT_CYC / 2) begin
				sh = {sh[14:0], sw};
				n = n + 1;
				if (n == 16) begin
					lastPkt <= sh;
					pkts <= pkts + 1;
					if (sh[15:8] == 8'h03 && hold < 0) begin
						hold = SETTLE;
					end
				end
			end
		end
	end
endmodule

// ---- wrxcs_top_test.sv ----
/*
 Self-checking bench for the charge supervisor with shortened timing.
 Assumes the transmitter model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
module wrxcs_top_test;
	localparam int BIT = 4;
	localparam int FAST = 200;
	localparam int SLOW = 1000;
	localparam int SETL = 330;
	localparam logic [7:0] RSN [11] = '{8'h00, 8'h02, 8'h02, 8'h03, 8'h03, 8'h06, 8'h06, 8'h08, 8'h01, 8'h00, 8'h03};
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        variantModified = 1'b0;
	logic [3:0]  tsAbove = 4'h0;
	logic [10:0] flt = 11'h000;
	logic        rectSurge = 1'b0;
	logic        rectAcceptable = 1'b0;
	logic        rectOverVolt = 1'b0;
	logic        rectAboveLockout = 1'b0;
	logic        loadAboveSyncEntry = 1'b0;
	logic        loadBelowSyncExit = 1'b0;
	logic [7:0]  controlErrorValue = 8'h00;
	wire         tsBiasEn, chargeEn, highImpedance, passSwitchOn, reducedVoltage, eptSent;
	wire         chargeStatusOut, chargeStatusOe, loadModSwitchA, loadModSwitchB, rectConverged;
	wire [1:0]   currentLimitSel, rectMode;
	wire [15:0]  lastPkt;
	int          pktCount, startCyc, zone, i, k, t1;
	int          bad_count = 0;
	int          compares = 0;
	int          cycles = 0;
	int          seed = 32'h7d96_8b7e;
	wrxcs_top #(.CE_FAST_CYC(FAST), .CE_SLOW_CYC(SLOW), .TS_BIAS_CYC(100), .TS_DGL_CYC(20), .TS_REL_CYC(200),
		.BIT_CYC(BIT)) wrxcs_top_i (.clk_sys, .rst_n, .variantModified, .tsAboveT1(tsAbove[0]),
		.tsAboveT2(tsAbove[1]), .tsAboveT3(tsAbove[2]), .tsAboveT4(tsAbove[3]), .tsHot(flt[4]), .tsCold(flt[3]),
		.ctrlAboveHigh(flt[9]), .ctrlBelowLow(flt[10]), .adapterPresent(flt[0]), .junctionHot(flt[1]),
		.ilimShorted(flt[2]), .rectSurge, .rectAcceptable, .rectOverVolt, .rectAboveLockout, .rectConverged,
		.rectConvergeFail(flt[7]), .loadAboveSyncEntry, .loadBelowSyncExit, .taperPhase(flt[8]),
		.battBelowTerm(flt[8]), .prechargeTimeout(flt[5]), .fastChargeTimeout(flt[6]), .controlErrorValue,
		.tsBiasEn, .chargeEn, .highImpedance, .passSwitchOn, .currentLimitSel, .reducedVoltage, .rectMode,
		.chargeStatusOut, .chargeStatusOe, .loadModSwitchA, .loadModSwitchB, .eptSent);
	wrxcs_tx_model #(.BIT_CYC(BIT)) wrxcs_tx_model_i (.clk_sys, .rst_n, .sw(loadModSwitchA),
		.frameOn(currentLimitSel == 2'h2), .converged(rectConverged), .lastPkt, .pktCount, .startCyc);
	always #2 clk_sys = ~clk_sys;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic waitPkts(input int n);
		int p0;
		p0 = pktCount;
		for (i = 0; i < 2500 * n && pktCount < p0 + n; i++) cyc(1);
		chk(16'(pktCount >= p0 + n), 16'h0001);
	endtask
	task automatic rstDut;
		rst_n = 1'b0;
		cyc(12);
		rst_n = 1'b1;
	endtask
	function automatic logic [1:0] expLimit(input logic modified, input int z);
		return (!modified && (z == 1 || z == 3)) ? 2'h1 : 2'h0;
	endfunction
	task automatic print_verdict;
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 80000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		controlErrorValue = $random(seed);
		rstDut();
		chk({tsBiasEn, chargeEn, rectMode}, 4'h8);
		rectAboveLockout = 1'b1;
		cyc(6);
		chk(rectMode, 2'h1);
		loadAboveSyncEntry = 1'b1;
		cyc(6);
		chk(rectMode, 2'h2);
		loadAboveSyncEntry = 1'b0;
		loadBelowSyncExit = 1'b1;
		cyc(6);
		chk(rectMode, 2'h1);
		rectAboveLockout = 1'b0;
		cyc(6);
		chk(rectMode, 2'h0);
		rectAboveLockout = 1'b1;
		tsAbove = 4'h3;
		cyc(SETL);
		chk(chargeEn, 1'b0);
		for (i = 0; i < 3000 && rectConverged !== 1'b1; i++) cyc(1);
		cyc(6);
		chk({chargeEn, chargeStatusOe}, 2'h3);
		chk(lastPkt, {8'h03, controlErrorValue});
		// Zones 0 and 4 come first so both window edges are always covered.
		for (k = 0; k < 16; k++) begin
			variantModified = $random(seed);
			zone = (k < 2) ? k * 4 : {$random(seed)} % 5;
			tsAbove = 4'hf >> (4 - zone);
			cyc(SETL);
			for (i = 0; i < 100 && currentLimitSel === 2'h2; i++) cyc(1);
			chk({chargeEn, chargeStatusOe}, (zone >= 1 && zone <= 3) ? 2'h3 : 2'h0);
			chk(currentLimitSel, expLimit(variantModified, zone));
			chk(reducedVoltage, zone == 3);
		end
		tsAbove = 4'h3;
		controlErrorValue = $random(seed);
		rectSurge = 1'b1;
		waitPkts(1);
		t1 = startCyc;
		waitPkts(1);
		chk(16'(startCyc - t1), FAST);
		chk(lastPkt, {8'h03, controlErrorValue});
		rectSurge = 1'b0;
		rectAcceptable = 1'b1;
		waitPkts(1);
		t1 = startCyc;
		waitPkts(1);
		chk(16'(startCyc - t1), SLOW);
		rectOverVolt = 1'b1;
		cyc(6);
		chk(passSwitchOn, 1'b0);
		waitPkts(1);
		t1 = startCyc;
		waitPkts(1);
		chk(16'(startCyc - t1), FAST);
		rectOverVolt = 1'b0;
		cyc(6);
		chk(passSwitchOn, 1'b1);
		for (k = 0; k < 11; k++) begin
			flt = 11'h001 << k;
			t1 = pktCount;
			rstDut();
			for (i = 0; i < 4000 && !(pktCount != t1 && lastPkt[15:8] === 8'h02); i++) cyc(1);
			chk(16'(i < 4000), 16'h0001);
			chk(lastPkt, {8'h02, RSN[k]});
			chk(highImpedance, 1'b1);
			t1 = pktCount;
			cyc(SLOW + 200);
			chk(16'(pktCount), 16'(t1));
		end
		print_verdict();
	end
endmodule
